// ### design/fsac_access_ctrl.sv
`timescale 1ns/1ps
// Function
// - Alias address = alias base + byte offset*32 + bit*4 selects one bit.
// - SRAM decodes at 0x2000_0000; alias access touches one bit atomically.
// - Flash erases in independent 1 KB blocks; only addressed block changes.
// - After erase every bit of the block reads one.
// - Program writes one 32-bit word, clearing bits only.
// - Protection unit is 2 KB, two adjacent erase blocks, one setting.
// - Read-only unit refuses program and erase, still serves reads and fetches.
// - Execute-only unit refuses changes and data reads; fetches still served.
// - Controller times program and erase itself from the reload count.
// - Reset loads reload with the value safe at maximum clock.
module fsac_access_ctrl #(
  parameter int unsigned PROG_US = fsac_pkg::PROG_TIME_US,
  parameter int unsigned ERASE_US = fsac_pkg::ERASE_TIME_US
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire fsac_pkg::fsac_req_t req,
  output logic req_ready,
  output fsac_pkg::fsac_rsp_t rsp,
  output logic op_done,
  input wire logic [7:0] prog_en,
  input wire logic [7:0] read_en,
  input wire logic usec_reload_we,
  input wire logic [7:0] usec_reload_val,
  output logic [7:0] microsecond_reload
);

  fsac_pkg::fsac_state_t s_ff;
  fsac_pkg::fsac_state_t nxt_s;

  logic [31:0] flash_mem [fsac_pkg::FLASH_WORDS];
  logic [31:0] sram_mem [fsac_pkg::SRAM_WORDS];

  logic tick;
  logic restart;
  logic fl_we;
  logic [11:0] fl_widx;
  logic [31:0] fl_wdat;
  logic sr_we;
  logic [9:0] sr_idx;
  logic [31:0] sr_wdat;
  logic [31:0] sr_mask;
  logic [31:0] fl_rd;
  logic [31:0] fl_old;
  logic [31:0] sr_rd;
  logic [31:0] alias_off;
  logic [11:0] alias_byte;
  logic [2:0] alias_bit;
  logic [4:0] alias_pos;
  logic in_fl;
  logic in_sr;
  logic in_al;
  logic [2:0] unit;
  logic [3:0] blk;
  logic take;
  logic is_chg;
  logic is_data_rd;

  fsac_usec_tick u_tick (
    .clk(clk),
    .arst_n(arst_n),
    .restart(restart),
    .reload(s_ff.usec_reload),
    .tick(tick)
  );

  // Address decode of the incoming request
  assign in_fl = req.addr < fsac_pkg::FLASH_LIM;
  assign in_sr = (req.addr >= fsac_pkg::SRAM_BASE) &&
                 (req.addr < fsac_pkg::SRAM_LIM);
  assign in_al = (req.addr >= fsac_pkg::ALIAS_BASE) &&
                 (req.addr < fsac_pkg::ALIAS_LIM);
  assign alias_off = req.addr - fsac_pkg::ALIAS_BASE;
  assign alias_byte = 12'(alias_off >> fsac_pkg::ALIAS_BYTE_SH);
  assign alias_bit = 3'(alias_off >> fsac_pkg::ALIAS_BIT_SH);
  assign alias_pos = {alias_byte[1:0], alias_bit};
  assign sr_mask = 32'h0000_0001 << alias_pos;
  assign sr_idx = in_al ? alias_byte[11:2]
                        : 10'(req.addr >> fsac_pkg::WORD_SH);
  assign unit = 3'(req.addr >> fsac_pkg::UNIT_SH);
  assign blk = 4'(req.addr >> fsac_pkg::BLK_SH);
  assign fl_rd = flash_mem[12'(req.addr >> fsac_pkg::WORD_SH)];
  assign fl_old = flash_mem[s_ff.widx];
  assign sr_rd = sram_mem[sr_idx];
  assign take = req.valid && s_ff.ready;
  assign is_chg = (req.op == fsac_pkg::OP_PROG) ||
                  (req.op == fsac_pkg::OP_ERASE);
  assign is_data_rd = (req.op == fsac_pkg::OP_READ) ||
                      (req.op == fsac_pkg::OP_DBG_READ);
  assign restart = take && is_chg && in_fl && prog_en[unit];

  always_comb begin
    nxt_s = s_ff;
    nxt_s.rsp = '0;
    nxt_s.done = 1'b0;
    fl_we = 1'b0;
    fl_widx = s_ff.widx;
    fl_wdat = fsac_pkg::ERASED_WORD;
    sr_we = 1'b0;
    sr_wdat = req.wdata;
    // Reload held while busy so a running operation keeps its timing
    if (usec_reload_we && s_ff.ready) begin
      nxt_s.usec_reload = usec_reload_val;
    end
    case (s_ff.st)
      fsac_pkg::S_IDLE: begin
        if (take) begin
          nxt_s.rsp.valid = 1'b1;
          if (in_fl) begin
            if (is_chg) begin
              if (!prog_en[unit]) begin
                nxt_s.rsp.err = 1'b1;
              end else begin
                nxt_s.ready = 1'b0;
                nxt_s.us_cnt = '0;
                nxt_s.wdata = req.wdata;
                nxt_s.widx = 12'(req.addr >> fsac_pkg::WORD_SH);
                if (req.op == fsac_pkg::OP_ERASE) begin
                  nxt_s.widx = {blk, 8'h00};
                  nxt_s.st = fsac_pkg::S_ERASE_WAIT;
                end else begin
                  nxt_s.st = fsac_pkg::S_PROG;
                end
              end
            end else if (is_data_rd && !read_en[unit]) begin
              nxt_s.rsp.err = 1'b1;
            end else if (req.op == fsac_pkg::OP_WRITE) begin
              // Flash changes only through program and erase
              nxt_s.rsp.err = 1'b1;
            end else begin
              nxt_s.rsp.rdata = fl_rd;
            end
          end else if (in_sr || in_al) begin
            if (is_chg) begin
              nxt_s.rsp.err = 1'b1;
            end else if (req.op == fsac_pkg::OP_WRITE) begin
              sr_we = 1'b1;
              if (in_al) begin
                // Single-cycle merge: no other bit of the word can move
                sr_wdat = req.wdata[0] ? (sr_rd | sr_mask)
                                       : (sr_rd & ~sr_mask);
              end
            end else if (in_al) begin
              nxt_s.rsp.rdata = {31'h0, |(sr_rd & sr_mask)};
            end else begin
              nxt_s.rsp.rdata = sr_rd;
            end
          end else begin
            nxt_s.rsp.err = 1'b1;
          end
        end
      end
      fsac_pkg::S_PROG: begin
        if (tick) begin
          if (s_ff.us_cnt == 16'(PROG_US - 1)) begin
            fl_we = 1'b1;
            fl_wdat = fl_old & s_ff.wdata;
            nxt_s.st = fsac_pkg::S_IDLE;
            nxt_s.ready = 1'b1;
            nxt_s.done = 1'b1;
          end else begin
            nxt_s.us_cnt = s_ff.us_cnt + 16'h0001;
          end
        end
      end
      fsac_pkg::S_ERASE_WAIT: begin
        if (tick) begin
          if (s_ff.us_cnt == 16'(ERASE_US - 1)) begin
            nxt_s.st = fsac_pkg::S_ERASE_FILL;
          end else begin
            nxt_s.us_cnt = s_ff.us_cnt + 16'h0001;
          end
        end
      end
      fsac_pkg::S_ERASE_FILL: begin
        // One word a cycle keeps the array single-ported for writes
        fl_we = 1'b1;
        fl_wdat = fsac_pkg::ERASED_WORD;
        nxt_s.widx = s_ff.widx + 12'h001;
        if (s_ff.widx[7:0] == 8'hFF) begin
          nxt_s.widx = s_ff.widx;
          nxt_s.st = fsac_pkg::S_IDLE;
          nxt_s.ready = 1'b1;
          nxt_s.done = 1'b1;
        end
      end
      default: begin
        nxt_s.st = fsac_pkg::S_IDLE;
        nxt_s.ready = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_ff <= '0;
      s_ff.st <= fsac_pkg::S_IDLE;
      s_ff.usec_reload <= fsac_pkg::USEC_RELOAD_RST;
      s_ff.ready <= 1'b1;
    end else begin
      s_ff <= nxt_s;
    end
  end

  always_ff @(posedge clk) begin
    if (fl_we) begin
      flash_mem[fl_widx] <= fl_wdat;
    end
    if (sr_we) begin
      sram_mem[sr_idx] <= sr_wdat;
    end
  end

  assign req_ready = s_ff.ready;
  assign rsp = s_ff.rsp;
  assign op_done = s_ff.done;
  assign microsecond_reload = s_ff.usec_reload;

  // Helper logic for the checks below
  logic [31:0] cyc_ff;
  logic [3:0] blk_ff;
  logic reload_wr_ff;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cyc_ff <= '0;
      blk_ff <= '0;
      reload_wr_ff <= 1'b0;
    end else begin
      cyc_ff <= restart ? 32'h0000_0001 : cyc_ff + 32'h0000_0001;
      blk_ff <= restart ? blk : blk_ff;
      reload_wr_ff <= reload_wr_ff | usec_reload_we;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  reload_rst_a: assert property (!reload_wr_ff |->
    microsecond_reload == fsac_pkg::USEC_RELOAD_RST)
    else $error("reload not at reset value");

  prog_time_a: assert property ((s_ff.st == fsac_pkg::S_PROG && fl_we)
    |-> cyc_ff == 32'(PROG_US) * (32'(s_ff.usec_reload) + 32'h1))
    else $error("program duration wrong");

  prog_clear_a: assert property ((s_ff.st == fsac_pkg::S_PROG && fl_we)
    |=> (flash_mem[$past(fl_widx)] &
    ~($past(fl_old) & $past(s_ff.wdata))) == 32'h0)
    else $error("program set a bit");

  erase_ones_a: assert property ((s_ff.st == fsac_pkg::S_ERASE_FILL) |=>
    flash_mem[$past(fl_widx)] == fsac_pkg::ERASED_WORD)
    else $error("erase wrote non-ones");

  erase_block_a: assert property (fl_we && s_ff.st ==
    fsac_pkg::S_ERASE_FILL |-> fl_widx[11:8] == blk_ff)
    else $error("erase left its block");

  ro_refuse_a: assert property ((take && in_fl && is_chg &&
    !prog_en[unit]) |=> rsp.valid && rsp.err && req_ready)
    else $error("protected change accepted");

  xo_read_a: assert property ((take && in_fl && is_data_rd &&
    !read_en[unit]) |=> rsp.valid && rsp.err)
    else $error("execute-only data read served");

  fetch_ok_a: assert property ((take && in_fl &&
    req.op == fsac_pkg::OP_FETCH) |=> rsp.valid && !rsp.err &&
    rsp.rdata == $past(fl_rd))
    else $error("fetch refused");

  alias_bit_a: assert property ((sr_we && in_al) |->
    ((sr_wdat ^ sr_rd) & ~sr_mask) == 32'h0 && sr_idx == req.addr[16:7] &&
    sr_mask == (32'h1 << req.addr[6:2]) &&
    req.wdata[0] == |(sr_wdat & sr_mask))
    else $error("alias write touched other bits");

  prog_cov_c: cover property (take && req.op == fsac_pkg::OP_PROG
    ##[1:1000] op_done);
  erase_cov_c: cover property (s_ff.st == fsac_pkg::S_ERASE_FILL
    ##1 op_done);
  alias_cov_c: cover property (sr_we && in_al);

endmodule

// ### design/fsac_usec_tick.sv
`timescale 1ns/1ps
module fsac_usec_tick (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic restart,
  input wire logic [7:0] reload,
  output logic tick
);

  fsac_pkg::fsac_tick_state_t s_ff;
  fsac_pkg::fsac_tick_state_t nxt_s;

  // One tick every reload+1 cycles; restart aligns the first tick
  always_comb begin
    nxt_s = s_ff;
    tick = 1'b0;
    if (restart) begin
      nxt_s.cnt = reload;
    end else if (s_ff.cnt == 8'h00) begin
      tick = 1'b1;
      nxt_s.cnt = reload;
    end else begin
      nxt_s.cnt = s_ff.cnt - 8'h01;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // Up-counter beside the down-counter, so a missed or early tick shows
  logic [7:0] gap_ff;
  logic [7:0] last_rl_ff;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      gap_ff <= 8'h00;
      last_rl_ff <= 8'h00;
    end else if (tick || restart) begin
      gap_ff <= 8'h00;
      last_rl_ff <= reload;
    end else begin
      gap_ff <= gap_ff + 8'h01;
    end
  end

  tick_period_a: assert property (@(posedge clk) disable iff (!arst_n)
    !restart |-> (tick == (gap_ff == last_rl_ff)))
    else $error("tick period broken");

endmodule

// ### include/fsac_pkg.sv
package fsac_pkg;

  // Highest system clock rate of the part, in MHz
  localparam int unsigned MAX_CLK_MHZ = 50;
  // Reload value that is safe at the highest clock rate
  localparam logic [7:0] USEC_RELOAD_RST = 8'(MAX_CLK_MHZ - 1);

  // Memory sizes in 32-bit words, and the protection unit count
  localparam int unsigned FLASH_WORDS = 4096;
  localparam int unsigned SRAM_WORDS = 1024;
  localparam int unsigned BLK_WORDS = 256;
  localparam int unsigned NUM_UNITS = 8;

  // Address map
  localparam logic [31:0] FLASH_LIM = 32'h0000_4000;
  localparam logic [31:0] SRAM_BASE = 32'h2000_0000;
  localparam logic [31:0] SRAM_LIM = 32'h2000_1000;
  localparam logic [31:0] ALIAS_BASE = 32'h2200_0000;
  localparam logic [31:0] ALIAS_LIM = 32'h2202_0000;

  // Alias offset = byte offset * 32 + bit number * 4
  localparam int unsigned ALIAS_BYTE_SH = 5;
  localparam int unsigned ALIAS_BIT_SH = 2;
  localparam int unsigned WORD_SH = 2;
  localparam int unsigned BLK_SH = 10;
  localparam int unsigned UNIT_SH = 11;

  // Program and erase durations in microsecond ticks
  localparam int unsigned PROG_TIME_US = 20;
  localparam int unsigned ERASE_TIME_US = 2000;

  localparam logic [31:0] ERASED_WORD = 32'hFFFF_FFFF;

  typedef enum logic [2:0] {
    OP_READ,
    OP_FETCH,
    OP_DBG_READ,
    OP_WRITE,
    OP_PROG,
    OP_ERASE
  } fsac_op_t;

  typedef enum logic [1:0] {
    S_IDLE,
    S_PROG,
    S_ERASE_WAIT,
    S_ERASE_FILL
  } fsac_st_t;

  typedef struct packed {
    logic valid;
    fsac_op_t op;
    logic [31:0] addr;
    logic [31:0] wdata;
  } fsac_req_t;

  typedef struct packed {
    logic valid;
    logic err;
    logic [31:0] rdata;
  } fsac_rsp_t;

  typedef struct packed {
    fsac_st_t st;
    logic [15:0] us_cnt;
    logic [11:0] widx;
    logic [31:0] wdata;
    logic [7:0] usec_reload;
    fsac_rsp_t rsp;
    logic done;
    logic ready;
  } fsac_state_t;

  typedef struct packed {
    logic [7:0] cnt;
  } fsac_tick_state_t;

endpackage

// ### tb/flash_sram_access_control_tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
  num_checks++; \
  if ((g) !== (e)) begin \
    mismatches++; \
    $display("Error %s expected %h seen %h", nm, e, g); \
  end \
end
module flash_sram_access_control_tb;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic go = 1'b0;
  logic we = 1'b0;
  fsac_pkg::fsac_op_t op = fsac_pkg::OP_READ;
  logic [31:0] addr = 32'h0;
  logic [31:0] wdata = 32'h0;
  logic [7:0] prog_en = 8'hFF;
  logic [7:0] read_en = 8'hFF;
  logic [7:0] rl_val = 8'h0;
  logic [7:0] reload;
  fsac_pkg::fsac_req_t req;
  fsac_pkg::fsac_rsp_t rsp;
  logic ready;
  logic done;
  int mismatches = 0;
  int num_checks = 0;
  int cyc = 0;

  always #10 clk = ~clk;

  fsac_bus_model fsac_bus_model_inst (
    .clk(clk), .arst_n(arst_n), .go(go), .op(op), .addr(addr),
    .wdata(wdata), .req_ready(ready), .req(req)
  );

  // Short tick counts keep each erase to a few hundred cycles
  fsac_access_ctrl #(.PROG_US(2), .ERASE_US(3)) fsac_access_ctrl_inst (
    .clk(clk), .arst_n(arst_n), .req(req), .req_ready(ready), .rsp(rsp),
    .op_done(done), .prog_en(prog_en), .read_en(read_en),
    .usec_reload_we(we), .usec_reload_val(rl_val),
    .microsecond_reload(reload)
  );

  task automatic summarize();
    $display("Checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      summarize();
    end
  end

  task automatic acc(fsac_pkg::fsac_op_t o, logic [31:0] a, logic [31:0] w,
                     logic e, logic [31:0] d);
    int i;
    @(negedge clk);
    op = o;
    addr = a;
    wdata = w;
    go = 1'b1;
    @(negedge clk);
    go = 1'b0;
    i = 0;
    while (rsp.valid !== 1'b1 && i < 20) begin
      @(negedge clk);
      i++;
    end
    `CHK("rsp_valid", 1'b1, rsp.valid)
    `CHK("rsp_err", e, rsp.err)
    if (!e) `CHK("rsp_rdata", d, rsp.rdata)
  endtask

  // Cycles from the answer to the done pulse; negative skips the count
  task automatic wt(int exp);
    int i;
    i = 0;
    `CHK("req_ready_busy", 1'b0, ready)
    while (done !== 1'b1 && i < 3000) begin
      @(negedge clk);
      i++;
    end
    `CHK("op_done_seen", 1'b1, done)
    if (exp >= 0) `CHK("op_cycles", exp, i)
  endtask

  task automatic scn_reload();
    `CHK("reload_rst", fsac_pkg::USEC_RELOAD_RST, reload)
    @(negedge clk);
    we = 1'b1;
    rl_val = 8'h01;
    @(negedge clk);
    we = 1'b0;
    `CHK("reload_new", 8'h01, reload)
  endtask

  // Reload 1 gives two cycles a tick: erase is 3 ticks plus 256 fill cycles
  task automatic scn_flash();
    acc(fsac_pkg::OP_ERASE, 32'h400, 32'h0, 1'b0, 32'h0);
    wt(262);
    acc(fsac_pkg::OP_READ, 32'h7FC, 32'h0, 1'b0, 32'hFFFFFFFF);
    acc(fsac_pkg::OP_PROG, 32'h400, 32'h0F0F0F0F, 1'b0, 32'h0);
    wt(4);
    acc(fsac_pkg::OP_PROG, 32'h400, 32'hFF00FF00, 1'b0, 32'h0);
    wt(4);
    acc(fsac_pkg::OP_READ, 32'h400, 32'h0, 1'b0, 32'h0F000F00);
    acc(fsac_pkg::OP_ERASE, 32'h0, 32'h0, 1'b0, 32'h0);
    wt(262);
    acc(fsac_pkg::OP_READ, 32'h0, 32'h0, 1'b0, 32'hFFFFFFFF);
    acc(fsac_pkg::OP_READ, 32'h400, 32'h0, 1'b0, 32'h0F000F00);
  endtask

  task automatic scn_protect();
    prog_en = 8'hFE;
    acc(fsac_pkg::OP_PROG, 32'h7FC, 32'h0, 1'b1, 32'h0);
    acc(fsac_pkg::OP_ERASE, 32'h0, 32'h0, 1'b1, 32'h0);
    `CHK("ready_refused", 1'b1, ready)
    acc(fsac_pkg::OP_READ, 32'h7FC, 32'h0, 1'b0, 32'hFFFFFFFF);
    read_en = 8'hFE;
    acc(fsac_pkg::OP_READ, 32'h400, 32'h0, 1'b1, 32'h0);
    acc(fsac_pkg::OP_DBG_READ, 32'h400, 32'h0, 1'b1, 32'h0);
    acc(fsac_pkg::OP_FETCH, 32'h400, 32'h0, 1'b0, 32'h0F000F00);
    prog_en = 8'hFF;
    read_en = 8'hFF;
  endtask

  task automatic scn_sram();
    acc(fsac_pkg::OP_WRITE, 32'h20000000, 32'h0, 1'b0, 32'h0);
    acc(fsac_pkg::OP_WRITE, 32'h2200002C, 32'h1, 1'b0, 32'h0);
    acc(fsac_pkg::OP_READ, 32'h20000000, 32'h0, 1'b0, 32'h00000800);
    acc(fsac_pkg::OP_READ, 32'h2200002C, 32'h0, 1'b0, 32'h1);
    acc(fsac_pkg::OP_WRITE, 32'h20000FFC, 32'h0, 1'b0, 32'h0);
    acc(fsac_pkg::OP_WRITE, 32'h2201FFFC, 32'h1, 1'b0, 32'h0);
    acc(fsac_pkg::OP_READ, 32'h20000FFC, 32'h0, 1'b0, 32'h80000000);
    // Bit 31 already set must survive an alias write to bit 0
    acc(fsac_pkg::OP_WRITE, 32'h2201FF80, 32'h1, 1'b0, 32'h0);
    acc(fsac_pkg::OP_READ, 32'h20000FFC, 32'h0, 1'b0, 32'h80000001);
    acc(fsac_pkg::OP_READ, 32'h2201FFFC, 32'h0, 1'b0, 32'h1);
    acc(fsac_pkg::OP_WRITE, 32'h2200002C, 32'h0, 1'b0, 32'h0);
    acc(fsac_pkg::OP_READ, 32'h20000000, 32'h0, 1'b0, 32'h0);
    acc(fsac_pkg::OP_READ, 32'h20001000, 32'h0, 1'b1, 32'h0);
  endtask

  // Mid-run reset: reload returns to its safe value, flash keeps its data
  task automatic scn_reset();
    @(negedge clk);
    arst_n = 1'b0;
    @(negedge clk);
    `CHK("ready_rst", 1'b1, ready)
    `CHK("reload_again", fsac_pkg::USEC_RELOAD_RST, reload)
    arst_n = 1'b1;
    acc(fsac_pkg::OP_READ, 32'h400, 32'h0, 1'b0, 32'h0F000F00);
  endtask

  initial begin
    repeat (6) @(negedge clk);
    arst_n = 1'b1;
    scn_reload();
    scn_flash();
    scn_protect();
    scn_sram();
    scn_reset();
    summarize();
  end
endmodule

// ### tb/fsac_bus_model.sv
`timescale 1ns/1ps
module fsac_bus_model (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic go,
  input wire fsac_pkg::fsac_op_t op,
  input wire logic [31:0] addr,
  input wire logic [31:0] wdata,
  input wire logic req_ready,
  output fsac_pkg::fsac_req_t req
);
  // Request is held until taken; released fields flip so stale data shows
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      req <= '0;
    end else if (go && !req.valid) begin
      req <= '{1'b1, op, addr, wdata};
    end else if (req.valid && req_ready) begin
      req.valid <= 1'b0;
      req.addr <= ~req.addr;
      req.wdata <= ~req.wdata;
    end
  end
endmodule
